// File: hw/flash_prog_cfg.svh
// Purpose: constants for the flash programming controller
// Assumes: 100 MHz reference clock
// Notes:   timing counts are whole clock cycles
`ifndef FLASH_PROG_CFG_SVH
`define FLASH_PROG_CFG_SVH
`define CLK_PERIOD_NS      10
`define SETUP_NS           100
`define PULSE_NS           1000
`define SETUP_CYC          ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC          ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECURITY_ADDR      16'hFFFF
`define ERASE_ADDR         16'h0000
`define ERASE_DATA         8'hFF
`define LOCK_BIT_POS       0
`define READ_INHIBIT_POS   1
`endif

// File: hw/flash_prog_pkg.sv
// Purpose: types for the flash programming controller
// Assumes: nothing
// Notes:   constants live in flash_prog_cfg.svh
package flash_prog_pkg;
    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE   = 3'h2,
        OP_EVERIFY = 3'h3
    } op_t;

    typedef struct packed {
        op_t         op;
        logic [15:0] addr;
        logic [7:0]  data;
    } cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic       mismatch;
    } rsp_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SETUP  = 5'b00010,
        ST_PULSE  = 5'b00100,
        ST_VSETUP = 5'b01000,
        ST_SAMPLE = 5'b10000
    } state_t;
endpackage : flash_prog_pkg

// File: hw/flash_prog_ctrl.sv
// Purpose: external programmer driving the flash programming pins of a microcontroller
// Assumes: pin inputs synchronous to i_ref_clk; high-voltage switching done off chip
// Notes:   one command at a time; program and erase are always followed by their verify
// Behaviour
// - hold reset high, latch low, store strobe high
// - address on ports, data byte bidirectional
// - program: select low, program level, strobes
// - verify after program: cs high, oe low
// - verify every programmed byte
// - erase verify: every byte reads all ones; the controller checks only the one addressed byte per command
// - clear lock bit only after full image; the controller only checks that the last verify was clean
`timescale 1ns/10ps
`include "flash_prog_cfg.svh"
module flash_prog_ctrl #(
    parameter int SETUP_CYCLES = `SETUP_CYC,
    parameter int PULSE_CYCLES = `PULSE_CYC
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_cmd_valid,
    input  wire flash_prog_pkg::cmd_t  i_cmd,
    output logic                       o_cmd_ready,
    output logic                       o_rsp_valid,
    output flash_prog_pkg::rsp_t       o_rsp,
    output logic                       o_rst_pin,
    output logic                       o_addr_latch,
    output logic                       o_program_store_strobe,
    output logic                       o_erase_select_pin,
    output logic                       o_mode_select_b,
    output logic                       o_mode_select_c,
    output logic                       o_mode_select_d,
    output logic                       o_cs_n,
    output logic                       o_oe_n,
    output logic                       o_program_level,
    output logic                       o_erase_level,
    output logic [15:0]                o_addr,
    input  wire logic [7:0]            i_data,
    output logic [7:0]                 o_data,
    output logic                       o_data_oe
);
    // the phase counters are 16 bits wide, so longer phases cannot be served
    if (SETUP_CYCLES < 1 || PULSE_CYCLES < 1 ||
        SETUP_CYCLES > 65535 || PULSE_CYCLES > 65535) begin : g_bad_timing
        $error("timing counts out of range");
    end

    function automatic logic uses_erase(input flash_prog_pkg::op_t op);
        uses_erase = (op == flash_prog_pkg::OP_ERASE) ||
                     (op == flash_prog_pkg::OP_EVERIFY);
    endfunction : uses_erase

    flash_prog_pkg::state_t st_q, st_d;
    flash_prog_pkg::cmd_t   cmd_q;
    logic [15:0] cnt_q;
    logic        ready_q, rvalid_q, oe_q, cs_q, dataoe_q, esel_q, vpp_q, erase_lvl_q;
    logic [7:0]  rdata_q;
    logic        mism_q;
    logic        image_ok_q;

    wire take       = i_cmd_valid && ready_q;
    wire take_erase = uses_erase(i_cmd.op);
    wire is_erase   = uses_erase(cmd_q.op);
    wire is_write   = (cmd_q.op == flash_prog_pkg::OP_PROGRAM) ||
                      (cmd_q.op == flash_prog_pkg::OP_ERASE);
    wire cnt_done   = (cnt_q == 16'h0000);
    // a lock-clearing program needs a clean last verify; earlier bytes of the image are not checked
    wire lock_clear = (cmd_q.op == flash_prog_pkg::OP_PROGRAM) &&
                      (cmd_q.addr == `SECURITY_ADDR) && !cmd_q.data[`LOCK_BIT_POS];
    wire pulse_ok   = !lock_clear || image_ok_q;
    // erase verify expects all ones, program verify the written byte
    wire [7:0] expect_byte = is_erase ? `ERASE_DATA : cmd_q.data;
    // counts load one less so a phase lasts exactly its parameter in cycles
    wire [15:0] setup_n = SETUP_CYCLES[15:0] - 16'h0001;
    wire [15:0] pulse_n = PULSE_CYCLES[15:0] - 16'h0001;

    always_comb begin
        st_d = st_q;
        case (st_q)
            flash_prog_pkg::ST_IDLE:   if (take) st_d = flash_prog_pkg::ST_SETUP;
            flash_prog_pkg::ST_SETUP:  if (cnt_done) st_d = is_write ? flash_prog_pkg::ST_PULSE
                                                                     : flash_prog_pkg::ST_SAMPLE;
            flash_prog_pkg::ST_PULSE:  if (cnt_done) st_d = flash_prog_pkg::ST_VSETUP;
            flash_prog_pkg::ST_VSETUP: if (cnt_done) st_d = flash_prog_pkg::ST_SAMPLE;
            flash_prog_pkg::ST_SAMPLE: st_d = flash_prog_pkg::ST_IDLE;
            default:                   st_d = flash_prog_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_q     <= flash_prog_pkg::ST_IDLE;
            cmd_q    <= '0;
            cnt_q    <= 16'h0000;
            ready_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 8'h00;
            mism_q   <= 1'b0;
            cs_q     <= 1'b1;
            oe_q     <= 1'b1;
            dataoe_q <= 1'b0;
            esel_q   <= 1'b0;
            vpp_q    <= 1'b0;
            erase_lvl_q <= 1'b0;
            image_ok_q  <= 1'b0;
        end else begin
            st_q     <= st_d;
            rvalid_q <= 1'b0;
            ready_q  <= (st_d == flash_prog_pkg::ST_IDLE);
            cnt_q    <= cnt_done ? 16'h0000 : cnt_q - 16'h0001;
            case (st_q)
                flash_prog_pkg::ST_IDLE: begin
                    cs_q     <= 1'b1;
                    oe_q     <= 1'b1;
                    dataoe_q <= 1'b0;
                    if (take) begin
                        cmd_q  <= i_cmd;
                        // erase forces a0 low and data all ones
                        if (i_cmd.op == flash_prog_pkg::OP_ERASE) begin
                            cmd_q.addr <= `ERASE_ADDR;
                            cmd_q.data <= `ERASE_DATA;
                        end
                        esel_q      <= take_erase;
                        vpp_q       <= (i_cmd.op == flash_prog_pkg::OP_PROGRAM);
                        erase_lvl_q <= take_erase;
                        cnt_q  <= setup_n;
                    end else begin
                        esel_q      <= 1'b0;
                        vpp_q       <= 1'b0;
                        erase_lvl_q <= 1'b0;
                    end
                end
                flash_prog_pkg::ST_SETUP: begin
                    if (is_write) begin
                        dataoe_q <= 1'b1;
                        if (cnt_done) begin
                            // a refused lock clear keeps cs high; its verify then mismatches
                            cs_q  <= !pulse_ok;
                            cnt_q <= pulse_n;
                        end
                    end else begin
                        // read pulls both strobes low; erase verify uses cs high
                        cs_q <= (cmd_q.op == flash_prog_pkg::OP_EVERIFY);
                        oe_q <= 1'b0;
                    end
                end
                flash_prog_pkg::ST_PULSE: begin
                    if (cnt_done) begin
                        // data drops with cs; any hold past cs rising is left to pad timing
                        cs_q     <= 1'b1;
                        dataoe_q <= 1'b0;
                        cnt_q    <= setup_n;
                    end
                end
                flash_prog_pkg::ST_VSETUP: begin
                    // verify keeps the high level applied
                    oe_q <= 1'b0;
                end
                flash_prog_pkg::ST_SAMPLE: begin
                    rvalid_q <= 1'b1;
                    rdata_q  <= i_data;
                    mism_q   <= (cmd_q.op != flash_prog_pkg::OP_READ) &&
                                (i_data != expect_byte);
                    if (cmd_q.op != flash_prog_pkg::OP_READ)
                        image_ok_q <= (i_data == expect_byte);
                    oe_q     <= 1'b1;
                    cs_q     <= 1'b1;
                end
                default: begin
                    cs_q <= 1'b1;
                    oe_q <= 1'b1;
                end
            endcase
        end
    end

    // flash mode entry levels are held from reset release on, idle included; reset pin low only during i_sys_rst
    logic rstpin_q;
    logic latch_q;
    logic mode_low_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rstpin_q   <= 1'b0;
            latch_q    <= 1'b0;
            mode_low_q <= 1'b0;
        end else begin
            rstpin_q   <= 1'b1;
            latch_q    <= 1'b0;
            mode_low_q <= 1'b0;
        end
    end

    assign o_rst_pin              = rstpin_q;
    assign o_addr_latch           = latch_q;
    assign o_program_store_strobe = rstpin_q;
    assign o_erase_select_pin     = esel_q;
    assign o_mode_select_b        = mode_low_q;
    assign o_mode_select_c        = mode_low_q;
    assign o_mode_select_d        = mode_low_q;
    assign o_cs_n                 = cs_q;
    assign o_oe_n                 = oe_q;
    assign o_program_level        = vpp_q;
    assign o_erase_level          = erase_lvl_q;
    assign o_addr                 = cmd_q.addr;
    assign o_data                 = cmd_q.data;
    assign o_data_oe              = dataoe_q;
    assign o_cmd_ready            = ready_q;
    assign o_rsp_valid            = rvalid_q;
    assign o_rsp                  = {rdata_q, mism_q};
endmodule : flash_prog_ctrl

// File: verification/flash_device_model.sv
// Purpose: flash device in programming mode
// Assumes: clockless; voltage levels are flags
// Notes:   a released bus shows the inverted byte so stale data never passes
`timescale 1ns/10ps
module flash_device_model (
    input  logic [2:0]  i_ctl,
    input  logic [3:0]  i_mode,
    input  logic        i_cs_n,
    input  logic        i_oe_n,
    input  logic [1:0]  i_lvl,
    input  logic [15:0] i_addr,
    input  logic [7:0]  i_d,
    input  logic        i_d_oe,
    output logic [7:0]  o_bus
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    wire fm = i_ctl == 3'b101 && i_mode[2:0] == 3'h0;
    wire lk = !mem[16'hFFFF][0];
    wire vf = i_mode[3] ? i_lvl == 2'b01 : i_lvl == 2'b10;
    wire rd = fm && !i_oe_n && (i_cs_n ? vf : i_lvl == 2'b00 && !i_mode[3]);
    assign o_bus = rd ? (lk ? ~mem[i_addr] : mem[i_addr]) : i_d_oe ? i_d : ~last_q;
    always @* if (rd || i_d_oe) last_q = o_bus;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    always @(negedge i_cs_n) begin // writes only on a cs_n pulse
        if (fm && i_oe_n && !i_mode[3] && i_lvl == 2'b10 && !lk)
            mem[i_addr] &= i_d;
        if (fm && i_oe_n && i_mode[3] && i_lvl == 2'b01 && !i_addr[0] && i_d == 8'hFF)
            foreach (mem[i]) mem[i] = 8'hFF;
    end
endmodule : flash_device_model

// File: verification/flash_prog_ctrl_checker.sv
// Purpose: port assertions for the flash programming controller
// Assumes: one clock, synchronous reset
// Notes:   latencies allow one cycle of slack on the answer
`timescale 1ns/10ps
module flash_prog_ctrl_checker #(
    parameter int SETUP_CYCLES = 10,
    parameter int PULSE_CYCLES = 100
) (
    input logic                 i_ref_clk,
    input logic                 i_sys_rst,
    input logic                 i_cmd_valid,
    input flash_prog_pkg::cmd_t i_cmd,
    input logic                 o_cmd_ready,
    input logic                 o_rsp_valid,
    input logic                 o_rst_pin,
    input logic                 o_addr_latch,
    input logic                 o_program_store_strobe,
    input logic                 o_erase_select_pin,
    input logic                 o_cs_n,
    input logic                 o_oe_n,
    input logic                 o_program_level,
    input logic                 o_erase_level,
    input logic                 o_data_oe
);
    localparam int RD = SETUP_CYCLES + 2;
    localparam int RD1 = SETUP_CYCLES + 3;
    localparam int PG = 2 * SETUP_CYCLES + PULSE_CYCLES + 2;
    localparam int PG1 = 2 * SETUP_CYCLES + PULSE_CYCLES + 3;
    localparam int VF = SETUP_CYCLES + 1;
    wire take = i_cmd_valid && o_cmd_ready;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    property p_ent; !o_cs_n || !o_oe_n |-> o_rst_pin && !o_addr_latch && o_program_store_strobe; endproperty
    a_ent: assert property (p_ent) else $error("mode entry");
    property p_rd; !o_cs_n && !o_oe_n |-> !o_program_level && !o_erase_level && !o_erase_select_pin; endproperty
    a_rd: assert property (p_rd) else $error("read pins");
    property p_rel; !o_oe_n |-> !o_data_oe; endproperty
    a_rel: assert property (p_rel) else $error("bus clash");
    property p_pg; !o_cs_n && o_program_level |-> o_oe_n && o_data_oe && !o_erase_level; endproperty
    a_pg: assert property (p_pg) else $error("program pins");
    property p_vf; $rose(o_cs_n) && o_program_level |-> ##[1:VF] (!o_oe_n && o_cs_n); endproperty
    a_vf: assert property (p_vf) else $error("no verify");
    property p_er; !o_cs_n && o_erase_level |-> o_erase_select_pin && o_oe_n && o_data_oe; endproperty
    a_er: assert property (p_er) else $error("erase pins");
    property p_lat; take && i_cmd.op == 3'h0 |-> ##[RD:RD1] o_rsp_valid; endproperty
    a_lat: assert property (p_lat) else $error("read late");
    property p_ev; take && i_cmd.op == 3'h2 |-> ##[PG:PG1] o_rsp_valid; endproperty
    a_ev: assert property (p_ev) else $error("erase late");
    property p_idle; o_rsp_valid |-> o_cs_n && o_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("strobes on");
    cover property (take && i_cmd.op == 3'h1);
    cover property (take && i_cmd.op == 3'h2);
    cover property (take && i_cmd.op == 3'h3);
endmodule : flash_prog_ctrl_checker
bind flash_prog_ctrl flash_prog_ctrl_checker #(.SETUP_CYCLES(SETUP_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)) chk (.*);

// File: verification/flash_prog_ctrl_tb_top.sv
// Purpose: self-checking bench for the flash programming controller
// Assumes: short setup and pulse counts
// Notes:   device side is a behavioural model
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module flash_prog_ctrl_tb_top;
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_cmd_valid = 1'b0;
    flash_prog_pkg::cmd_t i_cmd = '0;
    flash_prog_pkg::rsp_t o_rsp;
    logic o_cmd_ready, o_rsp_valid, o_rst_pin, o_addr_latch, o_program_store_strobe;
    logic o_erase_select_pin, o_mode_select_b, o_mode_select_c, o_mode_select_d;
    logic o_cs_n, o_oe_n, o_program_level, o_erase_level, o_data_oe;
    logic [15:0] o_addr;
    logic [7:0]  o_data;
    wire  [7:0]  i_data;
    int failures = 0, comparisons = 0;
    flash_prog_ctrl #(.SETUP_CYCLES(1), .PULSE_CYCLES(2)) uut (.*);
    flash_device_model dev (.i_ctl({o_rst_pin, o_addr_latch, o_program_store_strobe}),
        .i_mode({o_erase_select_pin, o_mode_select_b, o_mode_select_c, o_mode_select_d}),
        .i_cs_n(o_cs_n), .i_oe_n(o_oe_n), .i_lvl({o_program_level, o_erase_level}),
        .i_addr(o_addr), .i_d(o_data), .i_d_oe(o_data_oe), .o_bus(i_data));
    task automatic test_done;
        $display("compared %0d, failed %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    // ready is a register, so testing it one step after the edge is race free
    task automatic op(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d);
        i_cmd_valid = 1'b1;
        i_cmd = {o, a, d};
        while (o_cmd_ready !== 1'b1) @(posedge i_ref_clk) #1;
        @(posedge i_ref_clk) #1;
        i_cmd_valid = 1'b0;
        while (o_rsp_valid !== 1'b1) @(posedge i_ref_clk) #1;
    endtask : op
    task automatic t_prog;
        op(3'h1, 16'h0123, 8'h5A);
        `CHK(o_rsp, {8'h5A, 1'b0})
        op(3'h1, 16'h0123, 8'hF0);
        `CHK(o_rsp, {8'h50, 1'b1})
        // last verify failed, so a lock clear must be held off and reported
        op(3'h1, 16'hFFFF, 8'hFE);
        `CHK(o_rsp, {8'hFF, 1'b1})
        op(3'h0, 16'h0123, 8'h00);
        `CHK(o_rsp, {8'h50, 1'b0})
        $display("t_prog done");
    endtask : t_prog
    task automatic t_erase;
        op(3'h2, 16'h0000, 8'hFF);
        `CHK(o_rsp, {8'hFF, 1'b0})
        op(3'h3, 16'h0123, 8'h00);
        `CHK(o_rsp, {8'hFF, 1'b0})
        $display("t_erase done");
    endtask : t_erase
    task automatic t_lock;
        op(3'h1, 16'hFFFF, 8'hFD);
        `CHK(o_rsp, {8'hFD, 1'b0})
        op(3'h1, 16'hFFFF, 8'hFC);
        `CHK(o_rsp.mismatch, 1'b1)
        op(3'h0, 16'h0123, 8'h00);
        `CHK(o_rsp.data !== 8'hFF, 1'b1)
        op(3'h2, 16'h0000, 8'hFF);
        op(3'h0, 16'hFFFF, 8'h00);
        `CHK(o_rsp.data, 8'hFF)
        $display("t_lock done");
    endtask : t_lock
    initial forever #5 i_ref_clk = ~i_ref_clk;
    initial begin
        repeat (4) @(posedge i_ref_clk);
        #1 i_sys_rst = 1'b0;
        t_prog;
        t_erase;
        t_lock;
        test_done;
    end
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        failures++;
        test_done;
    end
endmodule : flash_prog_ctrl_tb_top
